// File: eag_decoder.sv
// Purpose: decode operand_locator_field into a register or memory location
// Assumes: register file read port answers in the same cycle
// Notes:   one request at a time; start is ignored while busy
`timescale 1ns/1ps
`default_nettype none
module eag_decoder
  import eag_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [5:0]  eaField,
  input  wire logic [1:0]  opSize,
  input  wire logic        isWrite,
  input  wire logic        isJump,
  input  wire logic        implicitExc,
  input  wire logic [31:0] pcExt,
  output logic             extReq,
  output logic             extSpace,
  input  wire logic        extValid,
  input  wire logic [15:0] extWord,
  output logic [3:0]       regRdIdx,
  input  wire logic [31:0] regRdData,
  output logic             regWrEn,
  output logic [3:0]       regWrIdx,
  output logic [31:0]      regWrData,
  output logic             busy,
  output logic             done,
  output logic [2:0]       locKind,
  output logic [3:0]       regNum,
  output logic [31:0]      opAddr,
  output logic             addrSpace,
  output logic             alignErr,
  output logic [3:0]       laneMask,
  output logic             supStack,
  output logic             useStateWord
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_EXT, ST_BASE, ST_INDEX, ST_BD1, ST_BD2
  } eag_st_e;

  typedef struct packed {
    eag_st_e     st;
    logic [2:0]  mode;
    logic [2:0]  rn;
    logic [1:0]  size;
    logic        isWr;
    logic        isJmp;
    logic [31:0] pcx;
    logic [15:0] ext;
    logic [31:0] acc;
    logic [15:0] bdHi;
    logic        extReq;
    logic [3:0]  rdIdx;
    logic        wrEn;
    logic [3:0]  wrIdx;
    logic [31:0] wrData;
    logic        busy;
    logic        done;
    logic [2:0]  kind;
    logic [3:0]  regNum;
    logic [31:0] addr;
    logic        space;
    logic        alignErr;
    logic [3:0]  lanes;
    logic        supStack;
    logic        useSw;
  } eag_state_s;

  eag_state_s q;
  eag_state_s d;
  logic [31:0] scaledIdx;
  logic        fullFmt;
  logic        idxSup;

  assign fullFmt = q.ext[EXT_FULL_BIT];
  assign idxSup  = fullFmt & q.ext[EXT_IS_BIT];

  eag_index_calc u_idx (
    .extWord   (q.ext),
    .idxVal    (regRdData),
    .suppress  (idxSup),
    .scaledIdx (scaledIdx)
  );

  // closes a request: location, space and big-endian byte lanes
  function automatic eag_state_s fin(input eag_state_s s, input logic [31:0] a,
                                     input logic [2:0] k, input logic sp);
    eag_state_s r;
    r          = s;
    r.st       = ST_IDLE;
    r.extReq   = 1'b0;
    r.done     = 1'b1;
    r.kind     = k;
    r.addr     = a;
    r.space    = s.isWr ? SPACE_DATA : sp; // [RQ6] [RQ7]
    r.alignErr = (k == LOC_MEM) && (s.size != SIZE_BYTE) && a[0]; // [RQ2]
    if (s.size == SIZE_BYTE)
      r.lanes = LANE_MSB >> a[1:0]; // [RQ1]
    else if (s.size == SIZE_WORD)
      r.lanes = a[1] ? LANES_LO : LANES_HI; // [RQ1]
    else
      r.lanes = LANES_ALL;
    fin = r;
  endfunction

  function automatic eag_state_s bad(input eag_state_s s);
    bad = fin(s, '0, LOC_ILLEGAL, SPACE_DATA); // [RQ23]
  endfunction

  always_comb
  begin
    d      = q;
    d.done = 1'b0;
    d.wrEn = 1'b0;
    case (q.st)
      ST_IDLE:
        if (start)
        begin
          d.mode     = eaField[EA_MODE_HI:EA_MODE_LO]; // [RQ3]
          d.rn       = eaField[EA_REG_HI:EA_REG_LO]; // [RQ3]
          d.size     = opSize;
          d.isWr     = isWrite;
          d.isJmp    = isJump;
          d.pcx      = pcExt;
          d.acc      = '0;
          d.regNum   = {1'b0, eaField[EA_REG_HI:EA_REG_LO]};
          d.supStack = 1'b0;
          d.useSw    = 1'b0;
          if (implicitExc)
          begin
            d          = fin(d, '0, LOC_IMPLICIT, SPACE_DATA);
            d.regNum   = {1'b1, SP_NUM}; // [RQ8]
            d.supStack = 1'b1; // [RQ8]
            d.useSw    = 1'b1; // [RQ8]
          end
          else
          begin
            case (eaField[EA_MODE_HI:EA_MODE_LO])
              MODE_DREG:
                d = fin(d, '0, LOC_DREG, SPACE_DATA); // [RQ9]
              MODE_AREG:
              begin
                d        = fin(d, '0, LOC_AREG, SPACE_DATA); // [RQ10]
                d.regNum = {1'b1, eaField[EA_REG_HI:EA_REG_LO]}; // [RQ10]
                if (opSize == SIZE_BYTE)
                  d = bad(d);
              end
              MODE_IND, MODE_POSTINC, MODE_PREDEC:
              begin
                d.st    = ST_BASE;
                d.rdIdx = {1'b1, eaField[EA_REG_HI:EA_REG_LO]};
              end
              MODE_DISP, MODE_INDEX:
              begin
                d.st     = ST_EXT; // [RQ4]
                d.extReq = 1'b1;
              end
              default:
                case (eaField[EA_REG_HI:EA_REG_LO]) // [RQ21]
                  SUB_ABS_W, SUB_ABS_L:
                  begin
                    d.st     = ST_EXT;
                    d.extReq = 1'b1;
                  end
                  SUB_PC_DISP, SUB_PC_IDX:
                    if (isWrite)
                      d = bad(d); // pc-relative is read only
                    else
                    begin
                      d.st     = ST_EXT;
                      d.extReq = 1'b1;
                    end
                  SUB_IMM:
                    if (isWrite)
                      d = bad(d);
                    else
                      d = fin(d, pcExt, LOC_IMM, SPACE_PROG); // [RQ6]
                  default:
                    d = bad(d); // [RQ23]
                endcase
            endcase
          end
        end
      ST_EXT:
        if (extValid)
        begin
          d.ext    = extWord; // [RQ4]
          d.extReq = 1'b0;
          case (q.mode)
            MODE_DISP:
            begin
              d.st    = ST_BASE;
              d.rdIdx = {1'b1, q.rn};
            end
            MODE_INDEX:
              if (extWord[EXT_FULL_BIT] &&
                  (extWord[EXT_IIS_HI:EXT_IIS_LO] != IIS_NONE)) // [RQ22]
                d = bad(d);
              else if (extWord[EXT_FULL_BIT] &&
                       (extWord[EXT_BDSZ_HI:EXT_BDSZ_LO] == BDSZ_RSVD))
                d = bad(d);
              else
              begin
                d.st    = ST_BASE;
                d.rdIdx = {1'b1, q.rn};
              end
            default:
              case (q.rn)
                SUB_ABS_W:
                  d = fin(d, eag_sext16(extWord), LOC_MEM, SPACE_DATA);
                SUB_ABS_L:
                begin
                  d.bdHi   = extWord;
                  d.st     = ST_BD2;
                  d.extReq = 1'b1;
                end
                SUB_PC_DISP:
                  d = fin(d, q.pcx + eag_sext16(extWord), LOC_MEM, SPACE_PROG); // [RQ6]
                default:
                begin
                  // pc base ignores base suppress; index and brief/full handling as for address base
                  d.acc   = q.pcx;
                  d.st    = ST_INDEX;
                  d.rdIdx = {extWord[EXT_DA_BIT], extWord[EXT_IDX_HI:EXT_IDX_LO]}; // [RQ16]
                  if (extWord[EXT_FULL_BIT] &&
                      ((extWord[EXT_IIS_HI:EXT_IIS_LO] != IIS_NONE) ||
                       (extWord[EXT_BDSZ_HI:EXT_BDSZ_LO] == BDSZ_RSVD))) // [RQ22]
                    d = bad(d);
                end
              endcase
          endcase
        end
      ST_BASE:
        case (q.mode)
          MODE_IND:
            d = fin(d, regRdData, LOC_MEM, SPACE_DATA); // [RQ11]
          MODE_POSTINC:
          begin
            d        = fin(d, regRdData, LOC_MEM, SPACE_DATA);
            d.wrEn   = 1'b1;
            d.wrIdx  = q.rdIdx;
            d.wrData = regRdData + eag_step(q.size, q.rn); // [RQ12]
          end
          MODE_PREDEC:
          begin
            d        = fin(d, regRdData - eag_step(q.size, q.rn), LOC_MEM, SPACE_DATA); // [RQ13]
            d.wrEn   = 1'b1;
            d.wrIdx  = q.rdIdx;
            d.wrData = regRdData - eag_step(q.size, q.rn); // [RQ13]
          end
          MODE_DISP:
            d = fin(d, regRdData + eag_sext16(q.ext), LOC_MEM, SPACE_DATA); // [RQ14]
          default:
          begin
            // base suppress drops the address register from the sum
            d.acc   = (fullFmt && q.ext[EXT_BS_BIT]) ? '0 : regRdData; // [RQ20]
            d.st    = ST_INDEX;
            d.rdIdx = {q.ext[EXT_DA_BIT], q.ext[EXT_IDX_HI:EXT_IDX_LO]}; // [RQ16]
          end
        endcase
      ST_INDEX:
        if (!fullFmt)
          d = fin(d, q.acc + eag_sext8(q.ext[7:0]) + scaledIdx, LOC_MEM,
                  (q.isJmp || q.mode == MODE_SPECIAL) ? SPACE_PROG : SPACE_DATA); // [RQ15] [RQ19]
        else
        begin
          d.acc = q.acc + scaledIdx; // [RQ20]
          if (q.ext[EXT_BDSZ_HI:EXT_BDSZ_LO] == BDSZ_NULL)
            d = fin(d, q.acc + scaledIdx, LOC_MEM,
                    (q.mode == MODE_SPECIAL) ? SPACE_PROG : SPACE_DATA);
          else
          begin
            d.st     = ST_BD1; // [RQ4]
            d.extReq = 1'b1;
          end
        end
      ST_BD1:
        if (extValid)
        begin
          if (q.ext[EXT_BDSZ_HI:EXT_BDSZ_LO] == BDSZ_LONG)
          begin
            d.bdHi = extWord;
            d.st   = ST_BD2;
          end
          else
            d = fin(d, q.acc + eag_sext16(extWord), LOC_MEM,
                    (q.mode == MODE_SPECIAL) ? SPACE_PROG : SPACE_DATA); // [RQ20]
        end
      ST_BD2:
        if (extValid)
          d = fin(d, q.acc + {q.bdHi, extWord}, LOC_MEM,
                  (q.mode == MODE_SPECIAL && q.rn == SUB_PC_IDX) ? SPACE_PROG
                                                                 : SPACE_DATA); // [RQ20]
      default:
        d.st = ST_IDLE;
    endcase
    d.busy = (d.st != ST_IDLE);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '{st: ST_IDLE, lanes: LANES_ALL, default: '0};
    else
      q <= d;
  end

  assign extReq       = q.extReq;
  assign extSpace     = SPACE_PROG; // [RQ5]
  assign regRdIdx     = q.rdIdx;
  assign regWrEn      = q.wrEn;
  assign regWrIdx     = q.wrIdx;
  assign regWrData    = q.wrData;
  assign busy         = q.busy;
  assign done         = q.done;
  assign locKind      = q.kind;
  assign regNum       = q.regNum;
  assign opAddr       = q.addr;
  assign addrSpace    = q.space;
  assign alignErr     = q.alignErr;
  assign laneMask     = q.lanes;
  assign supStack     = q.supStack;
  assign useStateWord = q.useSw;

  // helper: base value seen in the base read cycle
  logic [31:0] baseSeen;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      baseSeen <= '0;
    else if (q.st == ST_BASE)
      baseSeen <= regRdData;
  end

  property p_write_data;
    @(posedge clk) disable iff (!rst_n)
      done && q.isWr && locKind == LOC_MEM |-> addrSpace == SPACE_DATA;
  endproperty
  a_write_data: assert property (p_write_data) // [RQ7]
    else $error("operand write not in data space");

  property p_fetch_done;
    @(posedge clk) disable iff (!rst_n)
      start && !busy |=> busy || done;
  endproperty
  a_fetch_done: assert property (p_fetch_done) // [RQ4]
    else $error("request not taken");

  // word fetches may stall at the partner, so only local steps are bounded
  property p_progress;
    @(posedge clk) disable iff (!rst_n)
      busy && !extReq |=> ##[0:1] (done || extReq);
  endproperty
  a_progress: assert property (p_progress) // [RQ4]
    else $error("request stuck without a word fetch");

  property p_dreg;
    @(posedge clk) disable iff (!rst_n)
      start && !busy && !implicitExc && eaField[5:3] == MODE_DREG
        |=> done && locKind == LOC_DREG && regNum == {1'b0, $past(eaField[2:0])};
  endproperty
  a_dreg: assert property (p_dreg) // [RQ9]
    else $error("data register direct wrong");

  property p_areg;
    @(posedge clk) disable iff (!rst_n)
      start && !busy && !implicitExc && eaField[5:3] == MODE_AREG && opSize != SIZE_BYTE
        |=> done && locKind == LOC_AREG && regNum == {1'b1, $past(eaField[2:0])};
  endproperty
  a_areg: assert property (p_areg) // [RQ10]
    else $error("address register direct wrong");

  property p_indirect;
    @(posedge clk) disable iff (!rst_n)
      start && !busy && !implicitExc && eaField[5:3] == MODE_IND
        |=> ##1 done && opAddr == baseSeen && regRdIdx == {1'b1, q.rn};
  endproperty
  a_indirect: assert property (p_indirect) // [RQ11]
    else $error("indirect address not register contents");

  property p_postinc;
    @(posedge clk) disable iff (!rst_n)
      done && regWrEn && q.mode == MODE_POSTINC
        |-> regWrData - opAddr == eag_step(q.size, q.rn) && opAddr == baseSeen;
  endproperty
  a_postinc: assert property (p_postinc) // [RQ12]
    else $error("postincrement step wrong");

  property p_predec;
    @(posedge clk) disable iff (!rst_n)
      done && regWrEn && q.mode == MODE_PREDEC
        |-> baseSeen - opAddr == eag_step(q.size, q.rn) && regWrData == opAddr;
  endproperty
  a_predec: assert property (p_predec) // [RQ13]
    else $error("predecrement step wrong");

  property p_disp;
    @(posedge clk) disable iff (!rst_n)
      done && q.mode == MODE_DISP && locKind == LOC_MEM
        |-> opAddr == baseSeen + eag_sext16(q.ext);
  endproperty
  a_disp: assert property (p_disp) // [RQ14]
    else $error("displacement sum wrong");

  property p_align;
    @(posedge clk) disable iff (!rst_n)
      done && locKind == LOC_MEM |-> alignErr == (opAddr[0] && q.size != SIZE_BYTE);
  endproperty
  a_align: assert property (p_align) // [RQ2]
    else $error("alignment flag wrong");

  property p_indirect_illegal;
    @(posedge clk) disable iff (!rst_n)
      q.st == ST_EXT && extValid && q.mode == MODE_INDEX && extWord[EXT_FULL_BIT]
        && extWord[EXT_IIS_HI:EXT_IIS_LO] != IIS_NONE |=> done && locKind == LOC_ILLEGAL;
  endproperty
  a_indirect_illegal: assert property (p_indirect_illegal) // [RQ22]
    else $error("memory indirect not refused");
endmodule
`default_nettype wire

// File: eag_far_model.sv
// Purpose: register file read port and extension word source
// Assumes: bench loads register values and the next two words
// Notes:   released word bus shows the inverted last word
`timescale 1ns/1ps
`default_nettype none
module eag_far_model
  import eag_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        slow,
  input  wire logic [31:0] regs [16],
  input  wire logic [15:0] words [2],
  input  wire logic        extReq,
  input  wire logic [3:0]  regRdIdx,
  output logic             extValid,
  output logic [15:0]      extWord,
  output logic [31:0]      regRdData
);
  logic [1:0]  waitQ;
  logic        nextQ;
  logic [15:0] lastQ;
  assign regRdData = regs[regRdIdx];
  assign extValid = extReq && (waitQ == (slow ? 2'h3 : 2'h1));
  assign extWord = extValid ? words[nextQ] : ~lastQ;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitQ <= 2'h0;
      nextQ <= 1'b0;
      lastQ <= 16'h0000;
    end
    else if (start)
    begin
      waitQ <= 2'h0;
      nextQ <= 1'b0;
    end
    else if (extValid)
    begin
      waitQ <= 2'h0;
      nextQ <= 1'b1;
      lastQ <= extWord;
    end
    else if (extReq)
      waitQ <= waitQ + 2'h1;
  end
endmodule
`default_nettype wire

// File: eag_index_calc.sv
// Purpose: sized and scaled index operand from an extension word
// Assumes: idxVal is the register named by the extension word
// Notes:   purely combinational, one adder-free path
`timescale 1ns/1ps
`default_nettype none
module eag_index_calc
  import eag_pkg::*;
(
  input  wire logic [15:0] extWord,
  input  wire logic [31:0] idxVal,
  input  wire logic        suppress,
  output var  logic [31:0] scaledIdx
);
  logic [31:0] sized;

  always_comb
  begin
    sized = extWord[EXT_WL_BIT] ? idxVal : eag_sext16(idxVal[15:0]); // [RQ17]
    case (extWord[EXT_SCL_HI:EXT_SCL_LO]) // [RQ18]
      2'h0:    scaledIdx = sized;
      2'h1:    scaledIdx = {sized[30:0], 1'b0};
      2'h2:    scaledIdx = {sized[29:0], 2'h0};
      default: scaledIdx = {sized[28:0], 3'h0};
    endcase
    if (suppress)
      scaledIdx = '0;
  end
endmodule
`default_nettype wire

// File: eag_pkg.sv
// Purpose: constants and helpers for the operand locator decoder
// Assumes: 16-bit instruction words, 32-bit addresses and registers
// Notes:   register index bit 3 set selects an address register
//
// Functional notes
// [RQ1] memory is big-endian: byte N is most significant, N plus three least
// [RQ2] word and long operands and instruction words sit on even addresses
// [RQ3] operand_locator_field splits into a 3-bit mode and a 3-bit register
// [RQ4] extension words following the operation word belong to the instruction
// [RQ5] operation and extension word fetches go to program space
// [RQ6] operand reads use data space, except immediate and pc-relative reads
// [RQ7] every operand write goes to data space
// [RQ8] trap and divide exceptions implicitly use supervisor stack and state word
// [RQ9] data register direct uses data_reg_n named by the register subfield
// [RQ10] address register direct uses addr_reg_n named by the register subfield
// [RQ11] register indirect address is the unmodified addr_reg_n contents
// [RQ12] postincrement adds 1, 2 or 4 after use; byte on stack adds 2
// [RQ13] predecrement subtracts 1, 2 or 4 before use; byte on stack subtracts 2
// [RQ14] displacement mode adds a sign-extended 16-bit displacement to addr_reg_n
// [RQ15] brief index: one word, base plus sign-extended low byte plus index
// [RQ16] extension bit 15 picks index register type, bits 14 to 12 its number
// [RQ17] extension bit 11 picks sign-extended word or full long index
// [RQ18] extension bits 10 to 9 scale the index by 1, 2, 4 or 8
// [RQ19] brief indexed accesses are data references except for jump instructions
// [RQ20] full index: base plus scaled index plus optional 16 or 32-bit base_offset
// [RQ21] mode all ones makes the register subfield a special-mode selector
// [RQ22] full format memory-indirect requests raise an illegal instruction
// [RQ23] unrecognised mode and register combinations are flagged illegal
package eag_pkg;
  localparam int EA_MODE_HI = 5;
  localparam int EA_MODE_LO = 3;
  localparam int EA_REG_HI  = 2;
  localparam int EA_REG_LO  = 0;

  localparam logic [2:0] MODE_DREG    = 3'h0;
  localparam logic [2:0] MODE_AREG    = 3'h1;
  localparam logic [2:0] MODE_IND     = 3'h2;
  localparam logic [2:0] MODE_POSTINC = 3'h3;
  localparam logic [2:0] MODE_PREDEC  = 3'h4;
  localparam logic [2:0] MODE_DISP    = 3'h5;
  localparam logic [2:0] MODE_INDEX   = 3'h6;
  localparam logic [2:0] MODE_SPECIAL = 3'h7;

  localparam logic [2:0] SUB_ABS_W   = 3'h0;
  localparam logic [2:0] SUB_ABS_L   = 3'h1;
  localparam logic [2:0] SUB_PC_DISP = 3'h2;
  localparam logic [2:0] SUB_PC_IDX  = 3'h3;
  localparam logic [2:0] SUB_IMM     = 3'h4;

  localparam int EXT_DA_BIT   = 15;
  localparam int EXT_IDX_HI   = 14;
  localparam int EXT_IDX_LO   = 12;
  localparam int EXT_WL_BIT   = 11;
  localparam int EXT_SCL_HI   = 10;
  localparam int EXT_SCL_LO   = 9;
  localparam int EXT_FULL_BIT = 8;
  localparam int EXT_BS_BIT   = 7;
  localparam int EXT_IS_BIT   = 6;
  localparam int EXT_BDSZ_HI  = 5;
  localparam int EXT_BDSZ_LO  = 4;
  localparam int EXT_IIS_HI   = 2;
  localparam int EXT_IIS_LO   = 0;

  localparam logic [1:0] BDSZ_RSVD = 2'h0;
  localparam logic [1:0] BDSZ_NULL = 2'h1;
  localparam logic [1:0] BDSZ_WORD = 2'h2;
  localparam logic [1:0] BDSZ_LONG = 2'h3;
  localparam logic [2:0] IIS_NONE  = 3'h0;

  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  localparam logic [2:0] LOC_DREG     = 3'h0;
  localparam logic [2:0] LOC_AREG     = 3'h1;
  localparam logic [2:0] LOC_MEM      = 3'h2;
  localparam logic [2:0] LOC_IMM      = 3'h3;
  localparam logic [2:0] LOC_IMPLICIT = 3'h4;
  localparam logic [2:0] LOC_ILLEGAL  = 3'h5;

  localparam logic SPACE_DATA = 1'b0;
  localparam logic SPACE_PROG = 1'b1;

  localparam logic [2:0]  SP_NUM    = 3'h7;
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG = 32'h0000_0004;

  localparam logic [3:0] LANES_ALL = 4'hf;
  localparam logic [3:0] LANES_HI  = 4'hc;
  localparam logic [3:0] LANES_LO  = 4'h3;
  localparam logic [3:0] LANE_MSB  = 4'h8;

  function automatic logic [31:0] eag_sext16(input logic [15:0] w);
    eag_sext16 = {{16{w[15]}}, w};
  endfunction

  function automatic logic [31:0] eag_sext8(input logic [7:0] b);
    eag_sext8 = {{24{b[7]}}, b};
  endfunction

  // byte through the stack pointer still moves by two to keep it even
  function automatic logic [31:0] eag_step(input logic [1:0] sz, input logic [2:0] rn);
    if (sz == SIZE_BYTE)
      eag_step = (rn == SP_NUM) ? STEP_WORD : STEP_BYTE;
    else if (sz == SIZE_WORD)
      eag_step = STEP_WORD;
    else
      eag_step = STEP_LONG;
  endfunction
endpackage

// File: test_effective_address_generator.sv
// Purpose: random and corner checks of the operand locator decoder
// Assumes: far model answers extension requests promptly or slowly
// Notes:   odd-address word and misaligned long lane masks are left unchecked
`timescale 1ns/1ps
`default_nettype none
module test_effective_address_generator
  import eag_pkg::*;
;
  logic clk, rst_n, start, isWrite, isJump, implicitExc, slow, extValid;
  logic extReq, extSpace, regWrEn, busy, done, addrSpace, alignErr, supStack, useStateWord;
  logic [5:0]  eaField;
  logic [1:0]  opSize;
  logic [2:0]  locKind;
  logic [3:0]  regRdIdx, regWrIdx, regNum, laneMask;
  logic [15:0] extWord;
  logic [15:0] words [2];
  logic [31:0] pcExt, regRdData, regWrData, opAddr, r;
  logic [31:0] regs [16];
  int fails, checkCount, cycles, seed, i;

  eag_decoder uut (.clk(clk), .rst_n(rst_n), .start(start), .eaField(eaField),
    .opSize(opSize), .isWrite(isWrite), .isJump(isJump), .implicitExc(implicitExc),
    .pcExt(pcExt), .extReq(extReq), .extSpace(extSpace), .extValid(extValid),
    .extWord(extWord), .regRdIdx(regRdIdx), .regRdData(regRdData), .regWrEn(regWrEn),
    .regWrIdx(regWrIdx), .regWrData(regWrData), .busy(busy), .done(done),
    .locKind(locKind), .regNum(regNum), .opAddr(opAddr), .addrSpace(addrSpace),
    .alignErr(alignErr), .laneMask(laneMask), .supStack(supStack),
    .useStateWord(useStateWord));
  eag_far_model far (.clk(clk), .rst_n(rst_n), .start(start), .slow(slow), .regs(regs),
    .words(words), .extReq(extReq), .regRdIdx(regRdIdx), .extValid(extValid),
    .extWord(extWord), .regRdData(regRdData));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tally_and_finish;
    if (fails == 0 && checkCount > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] sx(input logic [15:0] w, input logic b);
    return b ? {{24{w[7]}}, w[7:0]} : {{16{w[15]}}, w};
  endfunction

  function automatic logic [31:0] idx(input logic [15:0] w);
    logic [31:0] v;
    v = regs[w[15:12]];
    if (!w[11])
      v = sx(v[15:0], 1'b0);
    return v << w[10:9];
  endfunction

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  // poke: a start while busy must be ignored
  task automatic run(input logic [2:0] md, input logic [2:0] rn, input logic [1:0] sz,
                     input logic wr, input logic jump_instr, input logic exc, input logic poke);
    logic [31:0] base, ea, stp;
    logic [15:0] w;
    logic [2:0]  kind;
    logic        spc;
    int          n;
    @(posedge clk);
    start <= 1'b1;
    eaField <= {md, rn};
    opSize <= sz;
    isWrite <= wr;
    isJump <= jump_instr;
    implicitExc <= exc;
    @(posedge clk);
    start <= 1'b0;
    if (poke)
    begin
      @(posedge clk);
      start <= 1'b1;
      eaField <= 6'h3f;
      @(posedge clk);
      start <= 1'b0;
      eaField <= {md, rn};
    end
    n = 0;
    #1;
    while (done !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(done, 1'b1);
    base = regs[{1'b1, rn}];
    w = words[0];
    stp = (sz == SIZE_BYTE) ? ((rn == SP_NUM) ? STEP_WORD : STEP_BYTE)
        : ((sz == SIZE_WORD) ? STEP_WORD : STEP_LONG);
    kind = LOC_MEM;
    spc = SPACE_DATA;
    ea = base;
    case (md)
      MODE_DREG: kind = LOC_DREG;
      MODE_AREG: kind = (sz == SIZE_BYTE) ? LOC_ILLEGAL : LOC_AREG;
      MODE_PREDEC: ea = base - stp;
      MODE_DISP: ea = base + sx(w, 1'b0);
      MODE_INDEX:
      begin
        ea = (w[8] && w[7]) ? '0 : base;
        ea = ea + ((w[8] && w[6]) ? '0 : idx(w));
        ea = ea + (!w[8] ? sx(w, 1'b1) : (w[5:4] == BDSZ_WORD) ? sx(words[1], 1'b0)
             : (w[5:4] == BDSZ_LONG) ? {words[1], words[1]} : '0);
        spc = w[8] ? SPACE_DATA : jump_instr;
        if (w[8] && (w[2:0] != IIS_NONE || w[5:4] == BDSZ_RSVD))
          kind = LOC_ILLEGAL;
      end
      MODE_SPECIAL:
      begin
        spc = (rn inside {SUB_PC_DISP, SUB_PC_IDX, SUB_IMM});
        case (rn)
          SUB_ABS_W: ea = sx(w, 1'b0);
          SUB_ABS_L: ea = {w, words[1]};
          SUB_PC_DISP: ea = pcExt + sx(w, 1'b0);
          SUB_PC_IDX: ea = pcExt + idx(w) + sx(w, 1'b1);
          default: ea = pcExt;
        endcase
        if (rn == SUB_IMM)
          kind = LOC_IMM;
        if (rn > SUB_IMM || (wr && spc))
          kind = LOC_ILLEGAL;
      end
      default: ea = base;
    endcase
    if (wr)
      spc = SPACE_DATA;
    if (exc)
      kind = LOC_IMPLICIT;
    chk(locKind, kind);
    chk(extSpace, SPACE_PROG);
    chk(regWrEn, kind == LOC_MEM && (md == MODE_POSTINC || md == MODE_PREDEC));
    if (regWrEn === 1'b1)
    begin
      chk(regWrIdx, {1'b1, rn});
      chk(regWrData, (md == MODE_POSTINC) ? base + stp : ea);
    end
    if (kind == LOC_DREG || kind == LOC_AREG)
      chk(regNum, {md[0], rn});
    if (kind == LOC_IMPLICIT)
      chk({supStack, useStateWord, regNum}, 6'h3f);
    if (kind == LOC_MEM || kind == LOC_IMM)
    begin
      chk(opAddr, ea);
      chk(addrSpace, spc);
    end
    if (kind == LOC_MEM)
    begin
      chk(alignErr, sz != SIZE_BYTE && ea[0]);
      if (!(sz != SIZE_BYTE && ea[0]) && (sz != SIZE_LONG || ea[1:0] == 2'h0))
        chk(laneMask, (sz == SIZE_BYTE) ? LANE_MSB >> ea[1:0] : (sz == SIZE_LONG)
            ? LANES_ALL : (ea[1] ? LANES_LO : LANES_HI));
    end
    @(posedge clk);
    #1;
    chk({done, busy, locKind}, {2'h0, kind});
  endtask

  initial
  begin
    seed = 32'he18a_868d;
    {rst_n, start, isWrite, isJump, implicitExc, slow, eaField, opSize} = '0;
    {pcExt, words[0], words[1]} = '0;
    for (i = 0; i < 16; i++)
      regs[i] = '0;
    repeat (2) @(posedge clk);
    #1;
    chk({laneMask, extSpace, done, busy}, 7'h7c);
    @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 400; i++)
    begin
      @(posedge clk);
      r = $random(seed);
      for (int k = 0; k < 16; k++)
        regs[k] <= $random(seed);
      pcExt <= $random(seed);
      words[1] <= $random(seed);
      words[0] <= (r[4:2] == MODE_INDEX && r[24])
                ? {r[31:24], r[14] ? {r[15], r[16], r[17], ~r[17] | r[18], 4'h0} : 8'h41}
                : {r[31:25], r[4:2] == MODE_SPECIAL ? 1'b0 : r[24], r[23:16]};
      slow <= r[13];
      run(r[4:2], r[7:5], (r[1:0] == 2'h3) ? SIZE_LONG : r[1:0], r[8], r[9],
          r[10] & r[11] & r[12], r[13] && r[4:2] inside {MODE_DISP, MODE_INDEX});
    end
    run(MODE_AREG, 3'h3, SIZE_BYTE, 1'b0, 1'b0, 1'b0, 1'b0);
    run(MODE_POSTINC, SP_NUM, SIZE_BYTE, 1'b0, 1'b0, 1'b0, 1'b0);
    run(MODE_PREDEC, SP_NUM, SIZE_BYTE, 1'b1, 1'b0, 1'b0, 1'b0);
    run(MODE_SPECIAL, SUB_IMM, SIZE_WORD, 1'b1, 1'b0, 1'b0, 1'b0);
    run(MODE_SPECIAL, 3'h7, SIZE_WORD, 1'b0, 1'b0, 1'b0, 1'b0);
    run(MODE_DREG, 3'h2, SIZE_LONG, 1'b0, 1'b0, 1'b1, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
